// ### inc/step_translator_pkg.sv
// Package with constants, register map and carrier types for the step translator
package step_translator_pkg;

  // ----------------------------------------------------------------------------
  // Summary of operation
  // ----------------------------------------------------------------------------
  // Summary of operation
  // - An index from 0 to 63 selects one of 64 phase table positions.
  // - Each position gives a sign and a six-bit magnitude current for both phases.
  // - Resolution code hi,lo: 00 full, 01 half, 10 quarter, 11 sixteenth.
  // - Each resolution bit is pin OR register bit; register bits reset to zero.
  // - Resolution affects only step pin motion, never serial step changes.
  // - Sixteenth step moves the index by one per step edge, per direction.
  // - Full step uses only positions 8, 24, 40 and 56.
  // - Half step uses only multiples of eight, 0 to 56.
  // - Quarter step uses only multiples of four, 0 to 60.
  // - After a change, next edge goes to the nearest valid position onward.
  // - Resolution may change between step edges; it applies from the next.
  // - One count is 5.625 electrical degrees; 0 is B full, A zero.
  // - All index arithmetic wraps modulo 64.
  // - Serial step value is added only on strobe rise after a run write.

  // ----------------------------------------------------------------------------
  // Widths and bus answers
  // ----------------------------------------------------------------------------
  localparam int unsigned INDEX_W  = 6;
  localparam int unsigned MAG_W    = 6;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PIN_W    = 5;
  localparam int unsigned QUART_N  = 17;

  // ----------------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RUN    = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_PHASE  = 12'h00C;

  // ----------------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------------
  localparam int unsigned RUN_ARMED_BIT   = 8;
  localparam int unsigned STAT_RES_LSB    = 6;
  localparam int unsigned STAT_DIR_BIT    = 8;
  localparam int unsigned PHASE_B_LSB     = 8;
  localparam logic [1:0]         RES_REG_RESET  = 2'h0;
  localparam logic [INDEX_W-1:0] INDEX_RESET    = 6'h00;
  localparam logic [INDEX_W-1:0] STEP_VAL_RESET = 6'h00;

  // Resolution codes, high bit then low bit
  localparam logic [1:0] RES_FULL      = 2'h0;
  localparam logic [1:0] RES_HALF      = 2'h1;
  localparam logic [1:0] RES_QUARTER   = 2'h2;
  localparam logic [1:0] RES_SIXTEENTH = 2'h3;

  // Grid pitch and offset of each resolution
  localparam logic [INDEX_W-1:0] PITCH_FULL    = 6'h10;
  localparam logic [INDEX_W-1:0] OFFSET_FULL   = 6'h08;
  localparam logic [INDEX_W-1:0] PITCH_HALF    = 6'h08;
  localparam logic [INDEX_W-1:0] PITCH_QUARTER = 6'h04;
  localparam logic [INDEX_W-1:0] PITCH_SIXTEEN = 6'h01;
  localparam logic [INDEX_W-1:0] OFFSET_NONE   = 6'h00;
  localparam logic [INDEX_W-1:0] QUARTER_TURN  = 6'h10;

  // Pin vector positions
  localparam int unsigned PIN_STEP   = 0;
  localparam int unsigned PIN_DIR    = 1;
  localparam int unsigned PIN_RES_LO = 2;
  localparam int unsigned PIN_RES_HI = 3;
  localparam int unsigned PIN_STROBE = 4;

  // ----------------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic             negative;
    logic [MAG_W-1:0] magnitude;
  } phase_current_t;

  typedef struct packed {
    phase_current_t phase_a;
    phase_current_t phase_b;
  } phase_pair_t;

endpackage : step_translator_pkg

// ### hw/phase_table_lookup.sv
// Phase current lookup: quarter-wave table unfolded over four quadrants
`timescale 1ns/1ps
`default_nettype none

module phase_table_lookup (
  input  wire logic [step_translator_pkg::INDEX_W-1:0] step_index,
  output var  step_translator_pkg::phase_pair_t        currents
);
  import step_translator_pkg::*;

  // Quarter sine, 0 to 90 degrees in 5.625 degree steps, full scale 63
  localparam logic [MAG_W-1:0] QUARTER [QUART_N] = '{
    6'h00, 6'h06, 6'h0C, 6'h12, 6'h18, 6'h1E, 6'h23, 6'h28, 6'h2D,
    6'h31, 6'h34, 6'h38, 6'h3A, 6'h3C, 6'h3E, 6'h3F, 6'h3F
  };

  logic [INDEX_W-1:0] b_index;

  // Sine at an index: quadrant picks mirror and sign
  function automatic phase_current_t sine_at(input logic [INDEX_W-1:0] idx);
    phase_current_t     r;
    logic [4:0]         pos;
    pos = {1'b0, idx[3:0]};
    if (idx[4]) begin
      pos = 5'(QUART_N - 1 - pos);
    end
    r.magnitude = QUARTER[pos];
    r.negative  = idx[5] && (r.magnitude != '0);
    return r;
  endfunction : sine_at

  // Phase A follows sine, phase B leads by a quarter turn so index 0 is B full
  assign b_index = INDEX_W'(step_index + QUARTER_TURN);
  always_comb begin
    currents.phase_a = sine_at(step_index);
    currents.phase_b = sine_at(b_index);
  end

endmodule : phase_table_lookup
`default_nettype wire

// ### hw/microstep_step_translator.sv
// Step and direction translator with APB register access and serial step path
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module microstep_step_translator (
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  input  wire logic                                    clk_en,
  // APB slave
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [step_translator_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [step_translator_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                              pstrb,
  output logic      [step_translator_pkg::DATA_W-1:0]  prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  // Host pins, asynchronous to pclk
  input  wire logic                                    step_pin,
  input  wire logic                                    dir_pin,
  input  wire logic                                    resolution_sel_lo,
  input  wire logic                                    resolution_sel_hi,
  input  wire logic                                    serial_strobe_n,
  // Translator outputs
  output logic      [step_translator_pkg::INDEX_W-1:0] step_index,
  output step_translator_pkg::phase_pair_t             phase_currents
);
  import step_translator_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0]   sync_a;
    logic [PIN_W-1:0]   sync_b;
    logic               step_prev;
    logic               strobe_prev;
    logic [INDEX_W-1:0] index;
    logic [1:0]         res_reg;
    logic [INDEX_W-1:0] step_change_value;
    logic               armed;
    logic               rd_ready;
    logic [DATA_W-1:0]  rd_data;
    phase_pair_t        currents;
  } state_t;

  // Synchroniser reset matches idle pin levels, so no false strobe edge after reset
  localparam logic [PIN_W-1:0] SYNC_IDLE = PIN_W'(1) << PIN_STROBE;

  localparam state_t STATE_RESET = '{
    sync_a:            SYNC_IDLE,
    sync_b:            SYNC_IDLE,
    step_prev:         1'b0,
    strobe_prev:       1'b1,
    index:             INDEX_RESET,
    res_reg:           RES_REG_RESET,
    step_change_value: STEP_VAL_RESET,
    armed:             1'b0,
    rd_ready:          1'b0,
    rd_data:           '0,
    currents:          '0
  };

  state_t             s;
  state_t             next_s;

  logic [PIN_W-1:0]   pins;
  logic               step_rise;
  logic               strobe_rise;
  logic               dir_up;
  logic [1:0]         res_eff;
  logic [INDEX_W-1:0] stepped_index;
  logic [INDEX_W-1:0] serial_index;
  logic               access_done;
  logic               wr_done;
  logic               addr_mapped;
  logic [DATA_W-1:0]  read_mux;
  phase_pair_t        lookup_currents;

  // ----------------------------------------------------------------------------
  // Grid stepping
  // ----------------------------------------------------------------------------
  // Moves to the nearest grid position strictly beyond idx in the chosen
  // direction. On-grid indices move by one pitch; off-grid ones snap to the
  // next point, so a resolution change never lands between grid points.
  function automatic logic [INDEX_W-1:0] grid_step(
    input logic [INDEX_W-1:0] idx,
    input logic [1:0]         res,
    input logic               up
  );
    logic [INDEX_W-1:0] pitch;
    logic [INDEX_W-1:0] offset;
    logic [INDEX_W-1:0] mask;
    logic [INDEX_W-1:0] rel;
    logic [INDEX_W-1:0] result;
    case (res)
      RES_FULL: begin
        pitch  = PITCH_FULL;
        offset = OFFSET_FULL;
      end
      RES_HALF: begin
        pitch  = PITCH_HALF;
        offset = OFFSET_NONE;
      end
      RES_QUARTER: begin
        pitch  = PITCH_QUARTER;
        offset = OFFSET_NONE;
      end
      default: begin
        pitch  = PITCH_SIXTEEN;
        offset = OFFSET_NONE;
      end
    endcase
    mask = INDEX_W'(pitch - PITCH_SIXTEEN);
    rel  = INDEX_W'(idx - offset);
    if (up) begin
      result = INDEX_W'((rel & ~mask) + pitch + offset);
    end else if ((rel & mask) != '0) begin
      result = INDEX_W'((rel & ~mask) + offset);
    end else begin
      result = INDEX_W'(rel - pitch + offset);
    end
    return result;
  endfunction : grid_step

  // ----------------------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------------------
  // All host pins are asynchronous; only the second stage is ever looked at
  always_comb begin
    pins             = '0;
    pins[PIN_STEP]   = step_pin;
    pins[PIN_DIR]    = dir_pin;
    pins[PIN_RES_LO] = resolution_sel_lo;
    pins[PIN_RES_HI] = resolution_sel_hi;
    pins[PIN_STROBE] = serial_strobe_n;
  end

  // Edge detection on the synchronised levels, one action per transition
  assign step_rise   = s.sync_b[PIN_STEP] && !s.step_prev;
  assign strobe_rise = s.sync_b[PIN_STROBE] && !s.strobe_prev;
  assign dir_up      = s.sync_b[PIN_DIR];

  // Pin level ORed with the register bit, sampled freshly at every step edge
  assign res_eff = {s.sync_b[PIN_RES_HI] | s.res_reg[1],
                    s.sync_b[PIN_RES_LO] | s.res_reg[0]};

  // ----------------------------------------------------------------------------
  // Index update paths
  // ----------------------------------------------------------------------------
  // Step pin motion honours the resolution grid
  assign stepped_index = step_rise ? grid_step(s.index, res_eff, dir_up) : s.index;

  // Serial motion adds the raw two's complement value and ignores resolution.
  // A step edge and a strobe in the same cycle both count; the host is meant
  // to keep them apart, so this only avoids losing either event.
  assign serial_index = (strobe_rise && s.armed) ?
                        INDEX_W'(stepped_index + s.step_change_value) :
                        stepped_index;

  // ----------------------------------------------------------------------------
  // Phase table
  // ----------------------------------------------------------------------------
  phase_table_lookup u_lookup (
    .step_index (s.index),
    .currents   (lookup_currents)
  );

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  // Read data is captured one edge after the request is seen, which lets the
  // data output come from flops at the cost of nothing when setup is clean.
  assign pready      = psel && penable && s.rd_ready && clk_en;
  assign access_done = pready;
  assign wr_done     = access_done && pwrite;

  always_comb begin
    addr_mapped = 1'b1;
    read_mux    = '0;
    case (paddr)
      ADDR_CONFIG: begin
        read_mux[1:0] = s.res_reg;
      end
      ADDR_RUN: begin
        read_mux[INDEX_W-1:0]  = s.step_change_value;
        read_mux[RUN_ARMED_BIT] = s.armed;
      end
      ADDR_STATUS: begin
        read_mux[INDEX_W-1:0]                    = s.index;
        read_mux[STAT_RES_LSB +: 2]              = res_eff;
        read_mux[STAT_DIR_BIT]                   = dir_up;
      end
      ADDR_PHASE: begin
        read_mux[MAG_W:0]                        = s.currents.phase_a;
        read_mux[PHASE_B_LSB +: MAG_W+1]         = s.currents.phase_b;
      end
      default: begin
        addr_mapped = 1'b0;
      end
    endcase
  end

  assign pslverr = pready && !addr_mapped;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (clk_en) begin
      // Two-stage synchroniser and edge history
      next_s.sync_a      = pins;
      next_s.sync_b      = s.sync_a;
      next_s.step_prev   = s.sync_b[PIN_STEP];
      next_s.strobe_prev = s.sync_b[PIN_STROBE];

      // Index moves by the step pin and the serial strobe
      next_s.index = serial_index;
      if (strobe_rise) begin
        next_s.armed = 1'b0;
      end

      // Registered phase currents follow the index one cycle later
      next_s.currents = lookup_currents;

      // Read data capture and access handshake
      if (psel && !s.rd_ready) begin
        next_s.rd_data  = read_mux;
        next_s.rd_ready = 1'b1;
      end
      if (access_done) begin
        next_s.rd_ready = 1'b0;
      end

      // Register writes; a run write arms even if a strobe consumes the old one
      if (wr_done && addr_mapped) begin
        case (paddr)
          ADDR_CONFIG: begin
            if (pstrb[0]) begin
              next_s.res_reg = pwdata[1:0];
            end
          end
          ADDR_RUN: begin
            if (pstrb[0]) begin
              next_s.step_change_value = pwdata[INDEX_W-1:0];
              next_s.armed             = 1'b1;
            end
          end
          default: begin
            next_s.res_reg = s.res_reg;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign prdata         = s.rd_data;
  assign step_index     = s.index;
  assign phase_currents = s.currents;

endmodule : microstep_step_translator
`default_nettype wire

// ### verification/step_host_model.sv
// Host controller model driving step, direction, resolution and strobe pins
`timescale 1ns/1ps
`default_nettype none

module step_host_model (
  input  wire logic pclk,
  output var  logic step_pin,
  output var  logic dir_pin,
  output var  logic resolution_sel_lo,
  output var  logic resolution_sel_hi,
  output var  logic serial_strobe_n
);
  // Idle levels; mode pins low so register bits keep full control
  initial begin
    step_pin          = 1'b0;
    dir_pin           = 1'b0;
    resolution_sel_lo = 1'b0;
    resolution_sel_hi = 1'b0;
    serial_strobe_n   = 1'b1;
  end

  // Mode and direction change only between step edges, then settle
  task automatic set_pins(input logic [1:0] r, input logic d);
    @(posedge pclk);
    resolution_sel_hi <= r[1];
    resolution_sel_lo <= r[0];
    dir_pin           <= d;
    repeat (3) @(posedge pclk);
  endtask : set_pins

  // One step pulse; w sets each level's length, so a slow host is possible
  task automatic pulse(input int w);
    @(posedge pclk);
    step_pin <= 1'b1;
    repeat (w) @(posedge pclk);
    step_pin <= 1'b0;
    repeat (w) @(posedge pclk);
  endtask : pulse

  // Strobe only while step is quiet, kept apart from any step edge
  task automatic strobe;
    @(posedge pclk);
    serial_strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
    serial_strobe_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : strobe
endmodule : step_host_model
`default_nettype wire

// ### verification/microstep_step_translator_checker.sv
// Port-level assertions for the step translator
`timescale 1ns/1ps
`default_nettype none

module microstep_step_translator_checker (
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             clk_en,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [11:0]                      paddr,
  input wire logic [31:0]                      pwdata,
  input wire logic [3:0]                       pstrb,
  input wire logic [31:0]                      prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  input wire logic                             step_pin,
  input wire logic                             dir_pin,
  input wire logic                             resolution_sel_lo,
  input wire logic                             resolution_sel_hi,
  input wire logic                             serial_strobe_n,
  input wire logic [5:0]                       step_index,
  input wire step_translator_pkg::phase_pair_t phase_currents
);
  import step_translator_pkg::*;
  logic [2:0] stp;
  logic [2:0] dr;
  logic [2:0] rlo;
  logic [2:0] rhi;
  logic [2:0] stb;
  logic [1:0] cfg;
  logic [1:0] res;

  // --------------------------------------------------------------------------
  // Shadow synchronisers and mode register
  // --------------------------------------------------------------------------
  // Mirrors the two-stage pin sync so expectations line up with the index edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stp <= 3'h0;
      dr  <= 3'h0;
      rlo <= 3'h0;
      rhi <= 3'h0;
      stb <= 3'h7;
      cfg <= 2'h0;
    end else if (clk_en) begin
      stp <= {stp[1:0], step_pin};
      dr  <= {dr[1:0], dir_pin};
      rlo <= {rlo[1:0], resolution_sel_lo};
      rhi <= {rhi[1:0], resolution_sel_hi};
      stb <= {stb[1:0], serial_strobe_n};
      if (psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_CONFIG) begin
        cfg <= pwdata[1:0];
      end
    end
  end
  assign res = {rhi[1] | cfg[1], rlo[1] | cfg[0]};

  // Next grid point strictly beyond the index, wrapping by six-bit arithmetic
  function automatic logic [5:0] nxt(input logic [5:0] i, input logic [1:0] r, input logic u);
    logic [5:0] p;
    logic [5:0] o;
    logic [5:0] v;
    p = (r == RES_FULL) ? 6'h10 : (r == RES_HALF) ? 6'h08 : (r == RES_QUARTER) ? 6'h04 : 6'h01;
    o = (r == RES_FULL) ? 6'h08 : 6'h00;
    v = i - o;
    if (u) v = v - (v % p) + p;
    else v = ((v % p) == 6'h00) ? v - p : v - (v % p);
    return v + o;
  endfunction : nxt

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence step_seen;
    clk_en && stp[1] && !stp[2] && !(stb[1] && !stb[2]);
  endsequence

  property grid_move(logic [1:0] m);
    step_seen ##0 (res == m) |=> step_index == nxt($past(step_index), m, $past(dr[1]));
  endproperty

  chk_full_grid: assert property (grid_move(RES_FULL))
    else $error("full step move wrong");
  chk_half_grid: assert property (grid_move(RES_HALF))
    else $error("half step move wrong");
  chk_quarter_grid: assert property (grid_move(RES_QUARTER))
    else $error("quarter step move wrong");
  chk_sixteenth_step: assert property (grid_move(RES_SIXTEENTH))
    else $error("sixteenth step move wrong");
  chk_index_quiet: assert property ($changed(step_index) |->
    $past(stp[1] && !stp[2]) || $past(stb[1] && !stb[2]))
    else $error("index moved without a cause");
  chk_status_view: assert property (pready && !pwrite && paddr == ADDR_STATUS
    && $past(psel && !penable) |-> prdata[8:0] == {$past(dr[1]), $past(res), $past(step_index)})
    else $error("status readback wrong");
  chk_phase_zero: assert property ($past(presetn) && $past(step_index) == 6'h00
    |-> phase_currents == 14'h003F)
    else $error("phase currents at index zero wrong");
  chk_unmapped_err: assert property (pready |-> pslverr == (paddr > ADDR_PHASE))
    else $error("slave error flag wrong");
endmodule : microstep_step_translator_checker

bind microstep_step_translator microstep_step_translator_checker chk_i (
  .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .step_pin, .dir_pin, .resolution_sel_lo, .resolution_sel_hi,
  .serial_strobe_n, .step_index, .phase_currents
);
`default_nettype wire

// ### verification/microstep_step_translator_tb.sv
// Self-checking testbench for the step translator
`timescale 1ns/1ps
`default_nettype none

module microstep_step_translator_tb;
  import step_translator_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              clk_en;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [3:0]        pstrb;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              step_pin;
  logic              dir_pin;
  logic              res_lo;
  logic              res_hi;
  logic              strobe_n;
  logic [5:0]        step_index;
  phase_pair_t       phase_currents;
  logic [31:0]       rd;
  logic              err;
  int                failures;
  int                compares;

  step_host_model host (.pclk(pclk), .step_pin(step_pin), .dir_pin(dir_pin),
    .resolution_sel_lo(res_lo), .resolution_sel_hi(res_hi), .serial_strobe_n(strobe_n));

  microstep_step_translator uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pin(step_pin), .dir_pin(dir_pin), .resolution_sel_lo(res_lo),
    .resolution_sel_hi(res_hi), .serial_strobe_n(strobe_n), .step_index(step_index),
    .phase_currents(phase_currents));

  // Free-running 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Serial path: arm a step change, then strobe
  task automatic go_to(input logic [5:0] t);
    apb(1'b1, ADDR_RUN, {26'h0, 6'(t - step_index)});
    host.strobe();
    check(32'(step_index), 32'(t));
  endtask : go_to

  task automatic t_reset;
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(phase_currents), 32'h0000_003F);
    apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset

  task automatic t_sixteenth;
    host.set_pins(RES_SIXTEENTH, 1'b1);
    host.pulse(3);
    check(32'(step_index), 32'h0000_0001);
    host.set_pins(RES_SIXTEENTH, 1'b0);
    host.pulse(8);
    host.pulse(3);
    check(32'(step_index), 32'h0000_003F);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_00FF);
    $display("test sixteenth done");
  endtask : t_sixteenth

  // Full, half and quarter grids walked once round the cycle, upward from 8
  task automatic t_walk;
    logic [5:0] e;
    logic [5:0] p;
    for (int m = 0; m < 3; m++) begin
      p = 6'h10 >> m;
      go_to(6'h08);
      e = 6'h08;
      host.set_pins(2'(m), 1'b1);
      for (int j = 0; j < 64 / p; j++) begin
        host.pulse(3);
        e = e + p;
        check(32'(step_index), 32'(e));
      end
    end
    $display("test walk done");
  endtask : t_walk

  // Off-grid 59 into each coarser mode, both directions
  task automatic t_change;
    logic [5:0] up [3];
    up = '{6'h08, 6'h00, 6'h3C};
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 2; d++) begin
        host.set_pins(RES_SIXTEENTH, 1'b1);
        go_to(6'h3B);
        host.set_pins(2'(m), 1'(d));
        host.pulse(3);
        check(32'(step_index), d ? 32'(up[m]) : 32'h0000_0038);
      end
    end
    $display("test change done");
  endtask : t_change

  // Pins ORed with register bits; a second strobe without a run write leaves the index
  task automatic t_reg_or;
    host.set_pins(RES_FULL, 1'b1);
    apb(1'b1, ADDR_CONFIG, 32'h0000_0003);
    go_to(6'h0A);
    host.strobe();
    check(32'(step_index), 32'h0000_000A);
    host.pulse(3);
    check(32'(step_index), 32'h0000_000B);
    apb(1'b1, ADDR_CONFIG, 32'h0000_0002);
    host.set_pins(RES_HALF, 1'b1);
    host.pulse(3);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_01CC);
    apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
    host.pulse(3);
    check(32'(step_index), 32'h0000_0010);
    go_to(6'h08);
    $display("test register or done");
  endtask : t_reg_or

  // Phase readback at 28, byte strobe gating and clock-enable freeze
  task automatic t_gate;
    go_to(6'h1C);
    apb(1'b0, ADDR_PHASE, 32'h0000_0000);
    check(rd, 32'h0000_7A18);
    check(32'(phase_currents), 32'h0000_0C7A);
    pstrb <= 4'hE;
    apb(1'b1, ADDR_CONFIG, 32'h0000_0003);
    pstrb <= 4'hF;
    apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    clk_en <= 1'b0;
    host.pulse(3);
    check(32'(step_index), 32'h0000_001C);
    clk_en <= 1'b1;
    $display("test gate done");
  endtask : t_gate

  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, about 36 times the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    failures = 0;
    compares = 0;
    presetn  = 1'b0;
    clk_en   = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    pstrb    = 4'hF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_sixteenth();
    t_walk();
    t_change();
    t_reg_or();
    t_gate();
    wrap_up();
  end
endmodule : microstep_step_translator_tb
`default_nettype wire
